// *** design/vdf_top.sv ***
// Top: register file and frame-start latching for the display fetch address block
`timescale 1ns/1ps
`default_nettype none
module vdf_top
  import vdf_pkg::*;
(
  input  wire logic        clk_i,          // Clock, 250 MHz
  input  wire logic        reset_n_i,      // Sync reset, active low
  input  wire logic [7:0]  reg_addr_i,     // Register address
  input  wire logic [7:0]  reg_wdata_i,    // Write data
  input  wire logic        reg_wr_i,       // Write strobe
  input  wire logic        reg_rd_i,       // Read strobe
  output logic      [7:0]  reg_rdata_o,    // Read data, cycle after strobe
  input  wire logic        rotated_display_mode_i, // Rotated mode select
  input  wire logic [8:0]  width_words_i,  // Visible words per line
  input  wire logic [9:0]  lines_i,        // Lines per frame
  input  wire logic        frame_start_i,  // Frame start pulse
  input  wire logic        rd_ready_i,     // Buffer accepts request
  output logic             rd_valid_o,     // Fetch request valid
  output logic      [15:0] rd_addr_o,      // Fetch byte address
  output logic             line_start_o,   // First word of line
  output logic             busy_o          // Frame in progress
);

  typedef struct packed {
    logic [7:0]  start_low;
    logic [6:0]  start_high;
    logic [7:0]  stride_ext;
    logic [14:0] act_start;
    logic [7:0]  act_stride;
    logic        act_rot;
    logic [7:0]  rdata;
    logic        fs;
  } vdf_regs_t;

  vdf_regs_t r_q, r_d;
  vdf_cfg_if cfg ();
  logic      busy;

  // ----------------------------------------------------------------------------
  // Register file and frame latch
  // ----------------------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    if (reg_wr_i) begin
      if (reg_addr_i == VDF_ADDR_START_LOW) begin
        r_d.start_low = reg_wdata_i;
      end else if (reg_addr_i == VDF_ADDR_START_HIGH) begin
        r_d.start_high = reg_wdata_i[VDF_HIGH_MSB:0];
      end else if (reg_addr_i == VDF_ADDR_STRIDE_EXT) begin
        r_d.stride_ext = reg_wdata_i;
      end
    end
    // Read data: reserved bit 7 and unmapped addresses read zero
    r_d.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == VDF_ADDR_START_LOW) begin
        r_d.rdata = r_q.start_low;
      end else if (reg_addr_i == VDF_ADDR_START_HIGH) begin
        r_d.rdata = {1'b0, r_q.start_high};
      end else if (reg_addr_i == VDF_ADDR_STRIDE_EXT) begin
        r_d.rdata = r_q.stride_ext;
      end else if (reg_addr_i == VDF_ADDR_STATUS) begin
        r_d.rdata = {6'h00, r_q.act_rot, busy};
      end
    end
    // Working copy changes only at frame start
    if (frame_start_i && !busy) begin
      r_d.act_start  = {r_q.start_high, r_q.start_low};
      r_d.act_stride = r_q.stride_ext;
      r_d.act_rot    = rotated_display_mode_i;
    end
    // Engine start one cycle after the latch
    r_d.fs = frame_start_i && !busy;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      r_q <= '{start_low: VDF_RST_START_LOW, start_high: VDF_RST_START_HIGH,
               stride_ext: VDF_RST_STRIDE_EXT, act_start: 15'h0000,
               act_stride: 8'h00, act_rot: 1'b0, rdata: 8'h00, fs: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // Latched values feed the engine; the engine starts one cycle after the latch
  assign cfg.start_addr = r_q.act_start;
  assign cfg.stride_ext = r_q.act_stride;
  assign cfg.rotated    = r_q.act_rot;
  assign reg_rdata_o    = r_q.rdata;
  assign busy_o         = busy;

  // ----------------------------------------------------------------------------
  // Fetch engine
  // ----------------------------------------------------------------------------
  vdf_fetch u_fetch (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .cfg           (cfg),
    .frame_start_i (r_q.fs),
    .width_words_i (width_words_i),
    .lines_i       (lines_i),
    .rd_ready_i    (rd_ready_i),
    .rd_valid_o    (rd_valid_o),
    .rd_addr_o     (rd_addr_o),
    .line_start_o  (line_start_o),
    .busy_o        (busy)
  );

endmodule
`default_nettype wire

// *** design/vdf_pkg.sv ***
// Package: register map, field layout and sizes for the display fetch address block
// ----------------------------------------------------------------------------
// What this block does
// - An 8-bit line offset register adds 0 to 255 extra words to every scan line's memory stride.
// - With a line offset of zero, consecutive scan lines are fetched back to back.
// - The visible words per line come from a separate width input; the offset only widens the stride.
// - Each frame starts fetching at the screen-1 start word, shown at the top-left pixel.
// - The start address is 15 bits: low register bits 7..0, high register bits 14..8, bit 7 reserved.
// - In normal orientation the start address counts 16-bit words, so one unit pans 16/8/4/2 pixels.
// - In rotated display mode the start address counts bytes, halving the pan step.
// - Screen 1 fills the top of each frame, fetched from upper left downward line by line.
// ----------------------------------------------------------------------------
package vdf_pkg;

  // Register offsets
  localparam logic [7:0] VDF_ADDR_START_LOW  = 8'h0c;
  localparam logic [7:0] VDF_ADDR_START_HIGH = 8'h0d;
  localparam logic [7:0] VDF_ADDR_STRIDE_EXT = 8'h12;
  localparam logic [7:0] VDF_ADDR_STATUS     = 8'h20;

  // Field layout
  localparam int VDF_START_W     = 15;
  localparam int VDF_HIGH_MSB    = 6;
  localparam int VDF_STRIDE_W    = 8;
  localparam int VDF_MEM_BYTES   = 40960;
  localparam int VDF_BADDR_W     = 16;

  // Reset values
  localparam logic [7:0] VDF_RST_START_LOW  = 8'h00;
  localparam logic [6:0] VDF_RST_START_HIGH = 7'h00;
  localparam logic [7:0] VDF_RST_STRIDE_EXT = 8'h00;

  // Fetch sequencer states
  typedef enum logic [2:0] {
    VDF_IDLE  = 3'b001,
    VDF_FETCH = 3'b010,
    VDF_WAIT  = 3'b100
  } vdf_state_t;

endpackage

// *** design/vdf_cfg_if.sv ***
// Interface: latched frame configuration passed from register file to fetch engine
`timescale 1ns/1ps
`default_nettype none
interface vdf_cfg_if;
  logic [14:0] start_addr;   // Start address for this frame
  logic [7:0]  stride_ext;   // Extra words per line for this frame
  logic        rotated;      // Byte addressing for this frame
  modport regs  (output start_addr, output stride_ext, output rotated);
  modport fetch (input start_addr, input stride_ext, input rotated);
endinterface
`default_nettype wire

// *** design/vdf_fetch.sv ***
// Fetch engine: walks byte addresses through one frame of screen 1
`timescale 1ns/1ps
`default_nettype none
module vdf_fetch
  import vdf_pkg::*;
(
  input  wire logic             clk_i,        // Clock
  input  wire logic             reset_n_i,    // Sync reset, active low
  vdf_cfg_if.fetch              cfg,          // Frame configuration
  input  wire logic             frame_start_i,// Frame start pulse
  input  wire logic [8:0]       width_words_i,// Visible words per line
  input  wire logic [9:0]       lines_i,      // Lines per frame
  input  wire logic             rd_ready_i,   // Buffer accepts request
  output logic                  rd_valid_o,   // Request valid
  output logic [15:0]           rd_addr_o,    // Byte address of request
  output logic                  line_start_o, // First word of a line
  output logic                  busy_o        // Frame in progress
);

  typedef struct packed {
    vdf_state_t  st;
    logic [15:0] line_base;
    logic [15:0] addr;
    logic [8:0]  word_cnt;
    logic [9:0]  line_cnt;
    logic        first;
  } vdf_fetch_t;

  vdf_fetch_t s_q, s_d;
  logic [15:0] stride_b;
  logic [15:0] start_b;

  // ----------------------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------------------
  // Stride in bytes: visible words plus extra words, two bytes each
  assign stride_b = 16'({7'h00, width_words_i} + {8'h00, cfg.stride_ext}) << 1;
  // Word offset doubles to bytes; rotated mode uses it as bytes directly
  assign start_b  = cfg.rotated ? {1'b0, cfg.start_addr}
                                : {cfg.start_addr, 1'b0};

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  // Next state
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      VDF_IDLE: begin
        if (frame_start_i && width_words_i != 9'h000 && lines_i != 10'h000) begin
          s_d.st        = VDF_FETCH;
          s_d.line_base = start_b;
          s_d.addr      = start_b;
          s_d.word_cnt  = 9'h000;
          s_d.line_cnt  = 10'h000;
          s_d.first     = 1'b1;
        end
      end
      VDF_FETCH: begin
        if (rd_ready_i) begin
          s_d.first = 1'b0;
          if (s_q.word_cnt == width_words_i - 9'h001) begin
            s_d.word_cnt = 9'h000;
            if (s_q.line_cnt == lines_i - 10'h001) begin
              s_d.st = VDF_IDLE;
            end else begin
              s_d.line_cnt  = s_q.line_cnt + 10'h001;
              s_d.line_base = s_q.line_base + stride_b;
              s_d.addr      = s_q.line_base + stride_b;
              s_d.first     = 1'b1;
            end
          end else begin
            s_d.word_cnt = s_q.word_cnt + 9'h001;
            s_d.addr     = s_q.addr + 16'h0002;
          end
        end
      end
      default: begin
        s_d.st = VDF_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_q <= '{st: VDF_IDLE, line_base: 16'h0000, addr: 16'h0000,
               word_cnt: 9'h000, line_cnt: 10'h000, first: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign rd_valid_o   = (s_q.st == VDF_FETCH);
  assign rd_addr_o    = s_q.addr;
  assign line_start_o = (s_q.st == VDF_FETCH) && s_q.first;
  assign busy_o       = (s_q.st != VDF_IDLE);

endmodule
`default_nettype wire

// *** verification/vdf_top_asserts.sv ***
// Checker: fetch request and register read properties of the top module
`timescale 1ns/1ps
`default_nettype none
module vdf_top_asserts (
  input wire logic        clk_i, // Clock
  input wire logic        reset_n_i, // Reset
  input wire logic        reg_rd_i, // Read strobe
  input wire logic [7:0]  reg_rdata_o, // Read data
  input wire logic        rotated_display_mode_i, // Byte mode
  input wire logic [8:0]  width_words_i, // Width
  input wire logic [9:0]  lines_i, // Lines
  input wire logic        frame_start_i, // Frame start
  input wire logic        rd_ready_i, // Ready
  input wire logic        rd_valid_o, // Valid
  input wire logic [15:0] rd_addr_o, // Address
  input wire logic        line_start_o, // Line start
  input wire logic        busy_o // Busy
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Frame start the engine has to take
  wire logic go = frame_start_i && !busy_o && width_words_i != 9'h0 && lines_i != 10'h0;
  property p_hold; rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_addr_o); endproperty
  a_hold: assert property (p_hold) else $error("stalled request not held");
  property p_step;
    rd_valid_o && rd_ready_i ##1 rd_valid_o && !line_start_o |-> rd_addr_o == $past(rd_addr_o) + 16'h2;
  endproperty
  a_step: assert property (p_step) else $error("word step not two bytes");
  property p_start; go |-> ##2 rd_valid_o && line_start_o && busy_o; endproperty
  a_start: assert property (p_start) else $error("frame did not start");
  property p_even; go && !rotated_display_mode_i |-> ##2 !rd_addr_o[0]; endproperty
  a_even: assert property (p_even) else $error("word mode start is odd");
  property p_ls; line_start_o |-> rd_valid_o; endproperty
  a_ls: assert property (p_ls) else $error("line start without request");
  property p_busy; rd_valid_o |-> busy_o; endproperty
  a_busy: assert property (p_busy) else $error("request outside frame");
  property p_rose; $rose(busy_o) |-> $past(frame_start_i, 2); endproperty
  a_rose: assert property (p_rose) else $error("frame began without start");
  property p_rdz; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside slot");
  c_stall: cover property (rd_valid_o && !rd_ready_i);
  c_rot: cover property (go && rotated_display_mode_i);
  c_line: cover property (rd_valid_o && rd_ready_i ##1 line_start_o);
endmodule
bind vdf_top vdf_top_asserts chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .rotated_display_mode_i(rotated_display_mode_i), .width_words_i(width_words_i),
  .lines_i(lines_i), .frame_start_i(frame_start_i), .rd_ready_i(rd_ready_i), .rd_valid_o(rd_valid_o),
  .rd_addr_o(rd_addr_o), .line_start_o(line_start_o), .busy_o(busy_o));
`default_nettype wire

// *** verification/vdf_buf_model.sv ***
// Partner: display buffer taking fetch requests, promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module vdf_buf_model (
  input  wire logic clk_i, // Clock
  input  wire logic slow_i, // Stall at random
  output var logic  rd_ready_o // Accepts request
);
  // Ready level, random while slow
  initial rd_ready_o = 1'b1;
  always @(posedge clk_i) begin
    rd_ready_o <= slow_i ? 1'($urandom_range(1)) : 1'b1;
  end
endmodule
`default_nettype wire

// *** verification/test_vdf_top.sv ***
// Testbench: register port and frame fetch addresses of the fetch address block
`timescale 1ns/1ps
`default_nettype none
module test_vdf_top;
  import vdf_pkg::*;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, wr = 1'b0, rd = 1'b0, rot = 1'b0, fs = 1'b0, slow = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [8:0]  width = 9'h1;
  logic [9:0]  lines = 10'h1;
  logic        ready, valid, lstart, busy;
  logic [15:0] raddr;
  logic [16:0] q[$];
  logic [7:0]  ra[4] = '{VDF_ADDR_START_LOW, VDF_ADDR_START_HIGH, VDF_ADDR_STRIDE_EXT, 8'h13};
  logic [7:0]  rv[4] = '{8'hff, 8'h7f, 8'hff, 8'h00};
  int          bad_count = 0, cmp_count = 0, cyc = 0, i;
  always #2 clk_i = ~clk_i;
  vdf_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .rotated_display_mode_i(rot), .width_words_i(width), .lines_i(lines),
    .frame_start_i(fs), .rd_ready_i(ready), .rd_valid_o(valid), .rd_addr_o(raddr), .line_start_o(lstart),
    .busy_o(busy));
  vdf_buf_model buf_u (.clk_i(clk_i), .slow_i(slow), .rd_ready_o(ready));
  // Log accepted requests, cut a hang short
  always @(posedge clk_i) begin
    if (valid && ready)
      q.push_back({lstart, raddr});
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Byte address of word k on line n of a frame
  function automatic logic [15:0] exp_addr(logic [14:0] s, logic [7:0] x, logic r, logic [8:0] w, int n, int k);
    return (r ? {1'b0, s} : {s, 1'b0}) + 16'(n * 2 * (w + x)) + 16'(2 * k);
  endfunction
  // One frame, new register values written while it runs
  task automatic run(input logic [14:0] s, input logic [7:0] x, input logic r, input logic [8:0] w,
                     input logic [9:0] n, input logic sl);
    int j;
    logic [16:0] g;
    logic [7:0]  d;
    @(posedge clk_i);
    rot <= r;
    width <= w;
    lines <= n;
    slow <= sl;
    wr_reg(VDF_ADDR_START_LOW, s[7:0]);
    wr_reg(VDF_ADDR_START_HIGH, {1'b1, s[14:8]});
    wr_reg(VDF_ADDR_STRIDE_EXT, x);
    q.delete();
    @(posedge clk_i);
    fs <= 1'b1;
    @(posedge clk_i);
    fs  <= 1'b0;
    rot <= ~r;
    rd_reg(VDF_ADDR_STATUS, d);
    chk_reg(d, {6'h00, r, w != 9'h000 && n != 10'h000}); // Mode latched, busy
    // A second start while the frame runs must be ignored
    if (int'(w) * int'(n) >= 3) begin
      @(posedge clk_i);
      fs <= 1'b1;
      @(posedge clk_i);
      fs <= 1'b0;
    end
    wr_reg(VDF_ADDR_START_LOW, 8'($urandom));
    wr_reg(VDF_ADDR_STRIDE_EXT, 8'($urandom));
    for (j = 0; j < 9000 && busy !== 1'b0; j++)
      @(posedge clk_i);
    chk(17'(q.size()), 17'(w * n)); // Word count per frame
    for (j = 0; j < w * n; j++) begin
      g = (q.size() > 0) ? q.pop_front() : 17'h1ffff;
      chk(g, {j % w == 0, exp_addr(s, x, r, w, j / w, j % w)}); // Address walk
    end
    $display("frame test done start %h stride %h rotated %b", s, x, r);
  endtask
  initial begin
    logic [7:0] d;
    void'($urandom(50570));
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // Reset values, then write all ones and read back
    for (i = 0; i < 4; i++) begin
      rd_reg(ra[i], d);
      chk_reg(d, 8'h00); // Reset value
      wr_reg(ra[i], 8'hff);
      rd_reg(ra[i], d);
      chk_reg(d, rv[i]); // Reserved bit, unmapped place
    end
    $display("register test done");
    run(15'h0000, 8'h00, 1'b0, 9'd4, 10'd3, 1'b0); // Back to back lines
    run(15'h7fff, 8'hff, 1'b0, 9'd3, 10'd2, 1'b1); // Widest stride, wrap
    run(15'h7fff, 8'hff, 1'b1, 9'd3, 10'd2, 1'b0); // Byte start
    run(15'h0001, 8'h01, 1'b1, 9'd1, 10'd1, 1'b0); // Single word
    run(15'h0100, 8'h04, 1'b0, 9'd3, 10'd2, 1'b0); // Scroll reference
    run(15'h0107, 8'h04, 1'b0, 9'd3, 10'd2, 1'b0); // Down one virtual line
    run(15'h0108, 8'h04, 1'b0, 9'd3, 10'd2, 1'b1); // Right one word
    run(15'h0005, 8'h02, 1'b0, 9'd0, 10'd2, 1'b0); // Zero width fetches nothing
    // Random frames keep start plus image inside the buffer
    for (i = 0; i < 12; i++)
      run(15'($urandom_range(17000)), 8'($urandom), 1'($urandom), 9'($urandom_range(8, 1)),
          10'($urandom_range(6, 1)), 1'($urandom)); // Random frames
    test_done();
  end
endmodule
`default_nettype wire
